// [rtl/rai_alarm.sv]
// alarm registers, match logic, alarm flag and open-drain interrupt drive
`include "rai_defs.svh"

module rai_alarm (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire rai_pkg::rai_wr_t  wr,
   input  wire logic [3:0]        rd_addr,
   input  wire rai_pkg::rai_time_t cur_time,
   input  wire logic              min_tick,
   output logic [7:0]             rd_data_q,
   output logic                   irq_out_q,
   output logic                   irq_oe_q,
   output logic                   stop_q,
   output logic                   crst_q
);

   // alarm register storage, all eight bits kept
   logic [7:0] alm_min_q;    // minute alarm
   logic [7:0] alm_hour_q;   // hour alarm
   logic [7:0] alm_wd_q;     // weekday mask or date alarm
   logic       wdsel_q;      // 0 weekday mask, 1 date
   logic       af_q;         // sticky alarm flag
   logic       aie_q;        // alarm interrupt enable

   // next values of the flag and enable
   logic       af_d;
   logic       aie_d;
   logic       irq_oe_d;

   // decoded write hits
   logic       wr_min;
   logic       wr_hour;
   logic       wr_wd;
   logic       wr_ext;
   logic       wr_flag;
   logic       wr_ctrl;

   // match terms
   logic       min_ok;
   logic       hour_ok;
   logic       wd_ok;
   logic       alarm_ev;     // one-cycle alarm event

   // write hit decode, shared by every register
   function automatic logic hit(input rai_pkg::rai_wr_t w,
                                input logic [3:0] ofs);
      hit = w.en && (w.addr == ofs);
   endfunction

   // read multiplexer; unused bits read as zero
   function automatic logic [7:0] rd_mux(input logic [3:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == `RAI_OFS_ALM_MIN) begin
         v = alm_min_q;
      end else if (a == `RAI_OFS_ALM_HOUR) begin
         v = alm_hour_q;
      end else if (a == `RAI_OFS_ALM_WD) begin
         v = alm_wd_q;
      end else if (a == `RAI_OFS_EXT) begin
         v[`RAI_BIT_WDSEL] = wdsel_q;
      end else if (a == `RAI_OFS_FLAG) begin
         v[`RAI_BIT_FLAG] = af_q;
      end else if (a == `RAI_OFS_CTRL) begin
         v[`RAI_BIT_IRQEN] = aie_q;
         v[`RAI_BIT_STOP]  = stop_q;
         v[`RAI_BIT_CRST]  = crst_q;
      end else begin
         v = 8'h00;   // offsets outside this block read zero
      end
      rd_mux = v;
   endfunction

   assign wr_min  = hit(wr, `RAI_OFS_ALM_MIN);
   assign wr_hour = hit(wr, `RAI_OFS_ALM_HOUR);
   assign wr_wd   = hit(wr, `RAI_OFS_ALM_WD);
   assign wr_ext  = hit(wr, `RAI_OFS_EXT);
   assign wr_flag = hit(wr, `RAI_OFS_FLAG);
   assign wr_ctrl = hit(wr, `RAI_OFS_CTRL);

   // field compares; a set disable bit forces a match
   always_comb begin
      min_ok  = alm_min_q[`RAI_BIT_DISABLE] ||
                (alm_min_q[6:0] == cur_time.minute);       // RULE5 RULE8
      hour_ok = alm_hour_q[`RAI_BIT_DISABLE] ||
                (alm_hour_q[5:0] == cur_time.hour);        // RULE5 RULE8
      if (alm_wd_q[`RAI_BIT_DISABLE]) begin
         wd_ok = 1'b1;                                     // RULE8 RULE9
      end else if (wdsel_q) begin
         wd_ok = (alm_wd_q[5:0] == cur_time.day);          // RULE2 RULE5
      end else begin
         // any selected weekday may hit
         wd_ok = |(alm_wd_q[6:0] & cur_time.weekday);      // RULE3 RULE4
      end
   end

   // evaluated only on the minute update, so setting the alarm to the
   // present time waits for the next advance and a matching minute
   // fires once instead of re-triggering every cycle
   assign alarm_ev = min_tick && min_ok && hour_ok && wd_ok &&
                     !stop_q && !crst_q;        // RULE6 RULE17 RULE18 RULE19

   // flag next value: set wins over a clear in the same cycle
   always_comb begin
      af_d = af_q;
      if (wr_flag && !wr.data[`RAI_BIT_FLAG]) begin
         af_d = 1'b0;                                      // RULE11
      end
      // a written 1 leaves the flag as it was
      if (alarm_ev) begin
         af_d = 1'b1;                                      // RULE6 RULE12
      end
   end

   // enable next value
   always_comb begin
      aie_d = aie_q;
      if (wr_ctrl) begin
         aie_d = wr.data[`RAI_BIT_IRQEN];
      end
   end

   // drive starts on an event with enable, holds with no timeout,
   // and drops in the cycle that the flag or the enable is cleared
   always_comb begin
      irq_oe_d = aie_d && af_d &&
                 (irq_oe_q || (alarm_ev && aie_q)); // RULE7 RULE13 RULE14
   end

   // alarm registers, spare bits included
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         alm_min_q  <= `RAI_RST_ALARM;
         alm_hour_q <= `RAI_RST_ALARM;
         alm_wd_q   <= `RAI_RST_ALARM;
      end else begin
         if (wr_min) begin
            alm_min_q <= wr.data;                          // RULE1
         end
         if (wr_hour) begin
            alm_hour_q <= wr.data;                         // RULE1 RULE10
         end
         if (wr_wd) begin
            alm_wd_q <= wr.data;                           // RULE1 RULE10
         end
      end
   end

   // week-or-date select
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wdsel_q <= `RAI_RST_BIT;
      end else if (wr_ext) begin
         wdsel_q <= wr.data[`RAI_BIT_WDSEL];               // RULE2
      end
   end

   // control bits: enable, stop and counter reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aie_q  <= `RAI_RST_BIT;
         stop_q <= `RAI_RST_BIT;
         crst_q <= `RAI_RST_BIT;
      end else begin
         aie_q <= aie_d;
         if (wr_ctrl) begin
            stop_q <= wr.data[`RAI_BIT_STOP];
            crst_q <= wr.data[`RAI_BIT_CRST];
         end
      end
   end

   // sticky alarm flag
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         af_q <= `RAI_RST_BIT;
      end else begin
         af_q <= af_d;                                     // RULE11
      end
   end

   // open-drain pin: level is always low, only the enable moves;
   // other sources share the wire, so high is left to the pull-up
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_oe_q  <= 1'b0;
         irq_out_q <= 1'b0;
      end else begin
         irq_oe_q  <= irq_oe_d;                  // RULE15 RULE16
         irq_out_q <= 1'b0;
      end
   end

   // registered read data, one cycle behind the address
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_mux(rd_addr);
      end
   end

   // checks on the behaviour above
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic no_wr;   // helper: no register write this cycle
   assign no_wr = !wr.en;

   flag_sets_a: assert property (alarm_ev |=> af_q)   // RULE6
      else $error("alarm event did not set the flag");

   flag_holds_a: assert property (
      af_q && !(wr_flag && !wr.data[`RAI_BIT_FLAG]) |=> af_q) // RULE11
      else $error("alarm flag dropped without a clear");

   flag_clear_a: assert property (
      wr_flag && !wr.data[`RAI_BIT_FLAG] && !alarm_ev |=> !af_q) // RULE13
      else $error("alarm flag not cleared by writing zero");

   one_no_set_a: assert property (
      !af_q && wr_flag && !alarm_ev |=> !af_q)    // RULE12
      else $error("writing one set the alarm flag");

   irq_drive_a: assert property (
      alarm_ev && aie_q && no_wr |=> irq_oe_q)    // RULE7
      else $error("interrupt not driven on enabled alarm");

   irq_cause_a: assert property (
      irq_oe_q |-> aie_q && af_q && !irq_out_q)   // RULE14
      else $error("interrupt driven without flag and enable");

   // two quiet cycles keep the pin driven in the second of them and the cycle after
   irq_persist_a: assert property (
      irq_oe_q && no_wr ##1 no_wr |-> irq_oe_q [*2]) // RULE16
      else $error("interrupt released without a clear");

   tick_only_a: assert property (
      $rose(af_q) |-> $past(min_tick) &&
                      !$past(stop_q) && !$past(crst_q)) // RULE17
      else $error("flag set outside an enabled minute update");

   all_off_a: assert property (
      min_tick && alm_min_q[7] && alm_hour_q[7] && alm_wd_q[7] &&
      !stop_q && !crst_q |=> af_q)                // RULE9
      else $error("all compares off but no event on minute");

   min_miss_a: assert property (
      !af_q && min_tick && !alm_min_q[7] &&
      alm_min_q[6:0] != cur_time.minute |=> !af_q) // RULE5
      else $error("flag set on minute mismatch");

   day_miss_a: assert property (
      !af_q && min_tick && !alm_wd_q[7] && !wdsel_q &&
      (alm_wd_q[6:0] & cur_time.weekday) == 7'h00 |=> !af_q) // RULE3
      else $error("flag set on an unselected weekday");

   spare_keep_a: assert property (
      wr_hour |=> alm_hour_q == $past(wr.data))   // RULE10
      else $error("hour alarm write not stored whole");

   cov_alarm_irq: cover property (alarm_ev && aie_q ##1 irq_oe_q);
   cov_aie_off: cover property (irq_oe_q ##1 !aie_q && !irq_oe_q);
   cov_date_hit: cover property (alarm_ev && wdsel_q);
   cov_clear_race: cover property (alarm_ev && wr_flag);

endmodule

// [inc/rai_defs.svh]
// register offsets, bit positions, reset values for the alarm block
// Summary of operation
// RULE1 - three alarm registers, disable bit seven
// RULE2 - select bit picks weekday mask or date
// RULE3 - weekday mode: seven-bit mask, many days
// RULE4 - mask bit0 Sunday through bit6 Saturday
// RULE5 - hour, minute, date compared as packed BCD
// RULE6 - enabled fields match: alarm flag set
// RULE7 - flag set with enable: pull interrupt low
// RULE8 - disabled register excluded from the match
// RULE9 - all three disabled: event every minute
// RULE10 - spare alarm bits are plain storage
// RULE11 - flag stays set until software writes 0
// RULE12 - writing 1 to flag does nothing
// RULE13 - clearing flag releases interrupt at once
// RULE14 - enable low: no drive; clearing releases
// RULE15 - interrupt pin shared with other sources
// RULE16 - alarm interrupt never times out itself
// RULE17 - no events while stop or counter reset
// RULE18 - no event for alarm set to now
// RULE19 - one evaluation per minute update
`ifndef RAI_DEFS_SVH
`define RAI_DEFS_SVH

// register offsets on the internal register port
`define RAI_OFS_ALM_MIN   4'h8
`define RAI_OFS_ALM_HOUR  4'h9
`define RAI_OFS_ALM_WD    4'hA
`define RAI_OFS_EXT       4'hD
`define RAI_OFS_FLAG      4'hE
`define RAI_OFS_CTRL      4'hF

// field positions
`define RAI_BIT_DISABLE   7
`define RAI_BIT_WDSEL     6
`define RAI_BIT_FLAG      3
`define RAI_BIT_IRQEN     3
`define RAI_BIT_STOP      1
`define RAI_BIT_CRST      0

// reset values
`define RAI_RST_ALARM     8'h00
`define RAI_RST_BIT       1'b0

`endif

// [inc/rai_pkg.sv]
// types shared by the alarm match and interrupt block
package rai_pkg;

   // current time as presented by the time counters
   typedef struct packed {
      logic [6:0] minute;   // packed BCD minute
      logic [5:0] hour;     // packed BCD hour
      logic [6:0] weekday;  // one-hot, bit0 Sunday
      logic [5:0] day;      // packed BCD day of month
   } rai_time_t;

   // register write request from the serial bus slave
   typedef struct packed {
      logic       en;       // one-cycle write strobe
      logic [3:0] addr;     // register offset
      logic [7:0] data;     // write data
   } rai_wr_t;

endpackage

// [dv/rai_host.sv]
// host model: register writes and reads, shared interrupt wire
module rai_host (
   input  wire logic        sys_clk,
   input  wire logic [7:0]  rd_data_q,
   input  wire logic        irq_oe_q,
   input  wire logic        other_oe,
   output rai_pkg::rai_wr_t wr,
   output logic [3:0]       rd_addr,
   output logic             irq_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // pulled up; low while any source drives it
   assign irq_n = !(irq_oe_q || other_oe);

   // idle bus from time zero
   initial begin
      wr = '0;
      rd_addr = 4'h0;
   end

   // one-cycle write strobe, then one idle edge
   task automatic put(input logic [3:0] a, input logic [7:0] v);
      wr <= '{1'b1, a, v};
      @(posedge sys_clk);
      wr <= '0;
      @(posedge sys_clk);
   endtask

   // read data lands one edge after the address is seen; taken
   // mid-cycle once settled, return on a rising edge so that the
   // caller keeps driving on rising edges only
   task automatic get(input logic [3:0] a, output logic [7:0] v);
      rd_addr <= a;
      @(posedge sys_clk);
      @(negedge sys_clk);
      v = rd_data_q;
      @(posedge sys_clk);
   endtask
endmodule

// [dv/rai_alarm_tb_top.sv]
// bench: alarm match table, then flag, enable and storage cases
module rai_alarm_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic               sel;  // date mode
      logic [7:0]         m;    // minute alarm
      logic [7:0]         h;    // hour alarm
      logic [7:0]         w;    // weekday or date alarm
      rai_pkg::rai_time_t t;    // time shown at the tick
      logic               hit;  // flag expected
   } rai_row_t;
   logic               sys_clk = 1'b0;
   logic               rst = 1'b1;
   logic               min_tick = 1'b0;
   logic               other_oe = 1'b0;   // another interrupt source
   rai_pkg::rai_time_t cur_time = '0;
   rai_pkg::rai_wr_t   wr;
   logic [3:0]         rd_addr;
   logic [7:0]         rd_data_q;
   logic               irq_oe_q;
   logic               irq_n;
   logic               irq_s;     // wire level taken mid-cycle
   logic               irq_lvl;   // level driven when enabled
   logic               stop_q;
   logic               crst_q;
   logic [7:0]         d;
   int                 n_fail = 0;
   int                 checks = 0;
   // last row matches any time, later cases lean on that
   rai_row_t rows [8] = '{
      '{1'b0, 8'h30, 8'h07, 8'h3E, '{7'h30, 6'h07, 7'h02, 6'h01}, 1'b1},
      '{1'b0, 8'h30, 8'h07, 8'h41, '{7'h30, 6'h07, 7'h02, 6'h01}, 1'b0},
      '{1'b0, 8'h30, 8'h07, 8'h41, '{7'h30, 6'h07, 7'h40, 6'h01}, 1'b1},
      '{1'b0, 8'h30, 8'h07, 8'h80, '{7'h30, 6'h07, 7'h08, 6'h01}, 1'b1},
      '{1'b1, 8'h30, 8'h07, 8'h15, '{7'h30, 6'h07, 7'h02, 6'h15}, 1'b1},
      '{1'b1, 8'h30, 8'h07, 8'h15, '{7'h30, 6'h07, 7'h02, 6'h01}, 1'b0},
      '{1'b0, 8'h59, 8'h80, 8'h01, '{7'h58, 6'h18, 7'h01, 6'h01}, 1'b0},
      '{1'b0, 8'h80, 8'h80, 8'h80, '{7'h12, 6'h23, 7'h04, 6'h09}, 1'b1}};

   always #4 sys_clk = ~sys_clk;

   // wire level sampled away from the rising edge
   always @(negedge sys_clk) irq_s <= irq_n;

   rai_alarm dut (.sys_clk(sys_clk), .rst(rst), .wr(wr),
      .rd_addr(rd_addr), .cur_time(cur_time), .min_tick(min_tick),
      .rd_data_q(rd_data_q), .irq_out_q(irq_lvl), .irq_oe_q(irq_oe_q),
      .stop_q(stop_q), .crst_q(crst_q));

   rai_host h (.sys_clk(sys_clk), .rd_data_q(rd_data_q),
      .irq_oe_q(irq_oe_q), .other_oe(other_oe), .wr(wr),
      .rd_addr(rd_addr), .irq_n(irq_n));

   // compare and count
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   // minute update with new time already shown
   task automatic tick(input rai_pkg::rai_time_t t);
      cur_time <= t;
      min_tick <= 1'b1;
      @(posedge sys_clk);
      min_tick <= 1'b0;
      @(posedge sys_clk);
   endtask

   // flag byte and wire level together
   task automatic flag_irq(input logic af, input logic lvl);
      h.get(4'hE, d);
      chk("flag", {4'h0, af, 3'h0}, d);
      chk("irq_n", {7'h00, lvl}, {7'h00, irq_s});
      chk("irq level", 8'h00, {7'h00, irq_lvl});
   endtask

   task automatic report_and_stop;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      h.put(4'hF, 8'h08);
      foreach (rows[i]) begin
         h.put(4'hD, {1'b0, rows[i].sel, 6'h00});
         h.put(4'h8, rows[i].m);
         h.put(4'h9, rows[i].h);
         h.put(4'hA, rows[i].w);
         h.put(4'hE, 8'h00);
         tick(rows[i].t);
         flag_irq(rows[i].hit, !rows[i].hit);
      end
      // write 1 to flag, long hold, then enable off
      h.put(4'hE, 8'h08);
      repeat (60) @(posedge sys_clk);
      flag_irq(1'b1, 1'b0);
      h.put(4'hF, 8'h00);
      flag_irq(1'b1, 1'b1);
      other_oe <= 1'b1;
      @(negedge sys_clk);
      chk("shared", 8'h00, {7'h00, irq_n});
      @(posedge sys_clk);
      other_oe <= 1'b0;
      // event with enable low: flag only
      h.put(4'hE, 8'h00);
      tick(rows[7].t);
      flag_irq(1'b1, 1'b1);
      // enable raised late does not drive; the next event does
      h.put(4'hF, 8'h08);
      flag_irq(1'b1, 1'b1);
      tick(rows[7].t);
      flag_irq(1'b1, 1'b0);
      h.put(4'hE, 8'h00);
      flag_irq(1'b0, 1'b1);
      // stop and counter reset each block events
      for (int k = 0; k < 2; k++) begin
         h.put(4'hF, k ? 8'h09 : 8'h0A);
         h.get(4'hF, d);
         chk("ctrl", k ? 8'h09 : 8'h0A, d);
         chk("stop", k ? 8'h00 : 8'h01, {7'h00, stop_q});
         chk("crst", k ? 8'h01 : 8'h00, {7'h00, crst_q});
         tick(rows[7].t);
         flag_irq(1'b0, 1'b1);
      end
      // matching time held, no further update
      h.put(4'hF, 8'h08);
      tick(rows[7].t);
      flag_irq(1'b1, 1'b0);
      h.put(4'hE, 8'h00);
      repeat (20) @(posedge sys_clk);
      flag_irq(1'b0, 1'b1);
      // alarm written equal to the time shown waits for a tick
      h.put(4'h8, 8'h12);
      h.put(4'h9, 8'h23);
      h.put(4'hA, 8'h04);
      repeat (4) @(posedge sys_clk);
      flag_irq(1'b0, 1'b1);
      tick(rows[7].t);
      flag_irq(1'b1, 1'b0);
      // clear write and event in one cycle: the set wins
      fork
         h.put(4'hE, 8'h00);
         tick(rows[7].t);
      join
      flag_irq(1'b1, 1'b0);
      // spare bits kept as storage
      h.put(4'h9, 8'hC0);
      h.get(4'h9, d);
      chk("hour spare", 8'hC0, d);
      h.put(4'hA, 8'hC0);
      h.get(4'hA, d);
      chk("day spare", 8'hC0, d);
      // only the select bit is kept in the extension byte
      h.put(4'hD, 8'hFF);
      h.get(4'hD, d);
      chk("select only", 8'h40, d);
      // reset in mid-run with the pin driven: all back to zero
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int a = 8; a < 16; a++) begin
         h.get(a[3:0], d);
         chk("reset read", 8'h00, d);
      end
      h.get(4'h3, d);
      chk("unmapped", 8'h00, d);
      chk("ctrl pins", 8'h00, {6'h00, stop_q, crst_q});
      flag_irq(1'b0, 1'b1);
      report_and_stop();
   end

   // watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      report_and_stop();
   end
endmodule
